/* acg_top.sv */
// Group-4 converter configuration bank: AXI4-Lite registers driving channel controls
//
// Added by the designer: the AXI4-Lite register port.
module acg_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [11:0] s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [11:0] s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // Mode inputs from the rest of the device
  input  wire logic        independent_pattern_select,
  input  wire logic        sixteen_input_mode,
  // Per-line test pattern controls, lines 13..16 at index 0..3
  output logic [3:0]       prbs_active,
  output logic [11:0]      test_pattern_sel,
  // High-pass filter
  output logic             highpass_enable_group4,
  output logic [3:0]       highpass_k_group4,
  output logic             highpass_k_illegal,
  // Input pair number per converter, 8 bits each
  output logic [31:0]      input_pair_num,
  // Power-down and inversion, index 0..3 is channel 13..16
  output logic [3:0]       digital_powerdown,
  output logic [3:0]       output_powerdown,
  output logic [3:0]       analog_powerdown,
  output logic [3:0]       data_invert_active
);
  logic        wr_go, wr_ok, rd_go, rd_ok;
  logic [11:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0]  wr_strb;
  logic [15:0] pat_hpf_q, insel_pat_q, pdn_inv_q;

  acg_axil_slave u_bus (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_go     (wr_go),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .wr_ok     (wr_ok),
    .rd_go     (rd_go),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .rd_ok     (rd_ok)
  );

  acg_regs u_regs (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .wr_go       (wr_go),
    .wr_addr     (wr_addr),
    .wr_data     (wr_data),
    .wr_strb     (wr_strb),
    .wr_ok       (wr_ok),
    .rd_addr     (rd_addr),
    .rd_data     (rd_data),
    .rd_ok       (rd_ok),
    .pat_hpf_q   (pat_hpf_q),
    .insel_pat_q (insel_pat_q),
    .pdn_inv_q   (pdn_inv_q)
  );

  // Field views, line 13 at index 0
  logic [3:0]  prbs_enable;
  logic [2:0]  test_pattern_out13, test_pattern_out14;
  logic [2:0]  test_pattern_out15, test_pattern_out16;
  logic [3:0]  k_field;
  logic [3:0]  input_pair_sel;
  logic [3:0]  test_active;

  // Register bit 15 is line 13, bit 12 is line 16
  assign prbs_enable = {pat_hpf_q[acg_pkg::PRBS_EN_LSB], pat_hpf_q[acg_pkg::PRBS_EN_LSB+1],
                        pat_hpf_q[acg_pkg::PRBS_EN_LSB+2], pat_hpf_q[acg_pkg::PRBS_EN_LSB+3]};
  assign test_pattern_out13 = pat_hpf_q[acg_pkg::PAT13_LSB +: 3];
  assign test_pattern_out14 = pat_hpf_q[acg_pkg::PAT14_LSB +: 3];
  assign test_pattern_out15 = insel_pat_q[acg_pkg::PAT15_LSB +: 3];
  assign test_pattern_out16 = insel_pat_q[acg_pkg::PAT16_LSB +: 3];
  assign k_field = pat_hpf_q[acg_pkg::HPF_K_LSB +: 4];
  // Bit 11 is converter 13, bit 8 converter 16
  assign input_pair_sel = {insel_pat_q[acg_pkg::INSEL_LSB], insel_pat_q[acg_pkg::INSEL_LSB+1],
                           insel_pat_q[acg_pkg::INSEL_LSB+2], insel_pat_q[acg_pkg::INSEL_LSB+3]};

  function automatic logic [7:0] pair_of(input logic [7:0] conv, input logic sel);
    return 8'((conv << 1) - 8'h01 + {7'h00, sel});
  endfunction

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      test_active[i] = independent_pattern_select &&
                       (prbs_enable[i] || (test_pattern_sel[3*i +: 3] != 3'h0));
    end
  end

  // Test patterns per line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prbs_active      <= 4'h0;
      test_pattern_sel <= 12'h000;
    end else if (independent_pattern_select) begin
      prbs_active      <= prbs_enable; // [R1]
      test_pattern_sel <= {test_pattern_out16, test_pattern_out15,
                           test_pattern_out14, test_pattern_out13}; // [R2]
    end else begin
      prbs_active      <= 4'h0;
      test_pattern_sel <= 12'h000;
    end
  end

  // High-pass filter; k held at zero while bypassed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      highpass_enable_group4 <= 1'b0;
      highpass_k_group4      <= 4'h0;
      highpass_k_illegal     <= 1'b0;
    end else begin
      highpass_enable_group4 <= pat_hpf_q[acg_pkg::HPF_EN_BIT]; // [R5]
      highpass_k_group4      <= pat_hpf_q[acg_pkg::HPF_EN_BIT] ? k_field : 4'h0; // [R4]
      // Flags software breaking the legal range of k while the filter enable is 1
      highpass_k_illegal <= pat_hpf_q[acg_pkg::HPF_EN_BIT] &&
                            (k_field < acg_pkg::HPF_K_MIN || k_field > acg_pkg::HPF_K_MAX); // [R3]
    end
  end

  // Input pair per converter; only meaningful in 16-input mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_pair_num <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < 4; i++) begin
        input_pair_num[8*i +: 8] <= sixteen_input_mode ?
          pair_of(8'(13 + i), input_pair_sel[i]) : 8'h00; // [R6]
      end
    end
  end

  // Power-down and inversion; inversion suppressed while a test pattern is sent
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      digital_powerdown  <= 4'h0;
      output_powerdown   <= 4'h0;
      analog_powerdown   <= 4'h0;
      data_invert_active <= 4'h0;
    end else begin
      digital_powerdown  <= pdn_inv_q[acg_pkg::PDN_DIG_LSB +: 4]; // [R9]
      output_powerdown   <= pdn_inv_q[acg_pkg::PDN_OUT_LSB +: 4]; // [R9]
      analog_powerdown   <= pdn_inv_q[acg_pkg::PDN_ANA_LSB +: 4]; // [R9]
      data_invert_active <= pdn_inv_q[acg_pkg::INV_LSB +: 4] & ~test_active; // [R10]
    end
  end

  prbs_follow_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    independent_pattern_select && pat_hpf_q[15] |=> prbs_active[0])
    else $error("line 13 prbs not active");
  pattern_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
    !independent_pattern_select |=> test_pattern_sel == 12'h000 && prbs_active == 4'h0)
    else $error("pattern without independent select");
  pattern_copy_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
    independent_pattern_select |=> test_pattern_sel[2:0] == $past(pat_hpf_q[11:9]))
    else $error("line 13 pattern wrong");
  k_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
    !pat_hpf_q[0] |=> highpass_k_group4 == 4'h0 && !highpass_enable_group4)
    else $error("k applied while filter off");
  k_range_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
    pat_hpf_q[0] && pat_hpf_q[4:1] == 4'hb |=> highpass_k_illegal)
    else $error("illegal k not flagged");
  pair_sel_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
    sixteen_input_mode |=> input_pair_num[7:0] == (($past(insel_pat_q[11])) ? 8'h1a : 8'h19))
    else $error("converter 13 pair wrong");
  pdn_copy_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
    1'b1 |=> output_powerdown == $past(pdn_inv_q[11:8]))
    else $error("output power-down mismatch");
  invert_mask_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
    test_active[0] |=> !data_invert_active[0])
    else $error("inversion applied to test pattern");
endmodule // acg_top

/* acg_pkg.sv */
// Register map, field layout and reset values of the group-4 converter configuration bank
// Summary of operation
// R1: With independent select set, each line 13-16 sends PRBS when its enable bit is 1.
// R2: With independent select set, each line 13-16 takes its own 3-bit test pattern field.
// R3: Corner field holds k for the high-pass filter; only 2 to 10 is legal.
// R4: Corner setting reaches the group filter only while the filter enable is 1.
// R5: Filter enable bit 0 turns the high-pass filter on; zero bypasses it.
// R6: In 16-input mode converter n samples pair 2n-1 on 0, pair 2n on 1.
// R7: All fields are read/write and reset to zero.
// R8: Software writes zero to reserved bits; they never change device behaviour.
// R9: Power-down bits shut off digital block, output line or analog block of channel.
// R10: Invert bits invert converter data on lines 13-16 but never test patterns.
package acg_pkg;
  // Register indices; each register is one 32-bit word, byte address is four times
  localparam logic [7:0]  IDX_PAT_HPF    = 8'h39;
  localparam logic [7:0]  IDX_INSEL_PAT  = 8'h3b;
  localparam logic [7:0]  IDX_PDN_INV    = 8'h3c;
  localparam logic [11:0] ADDR_PAT_HPF   = {2'h0, IDX_PAT_HPF, 2'h0};
  localparam logic [11:0] ADDR_INSEL_PAT = {2'h0, IDX_INSEL_PAT, 2'h0};
  localparam logic [11:0] ADDR_PDN_INV   = {2'h0, IDX_PDN_INV, 2'h0};
  localparam logic [15:0] RST_PAT_HPF   = 16'h0000;
  localparam logic [15:0] RST_INSEL_PAT = 16'h0000;
  localparam logic [15:0] RST_PDN_INV   = 16'h0000;
  // Writable (non-reserved) bits of each register
  localparam logic [15:0] MASK_PAT_HPF   = 16'hffdf;
  localparam logic [15:0] MASK_INSEL_PAT = 16'h0ffc;
  localparam logic [15:0] MASK_PDN_INV   = 16'hffff;
  localparam int PRBS_EN_LSB   = 12;
  localparam int PAT13_LSB     = 9;
  localparam int PAT14_LSB     = 6;
  localparam int HPF_K_LSB     = 1;
  localparam int HPF_EN_BIT    = 0;
  localparam int INSEL_LSB     = 8;
  localparam int PAT15_LSB     = 5;
  localparam int PAT16_LSB     = 2;
  localparam int PDN_DIG_LSB   = 12;
  localparam int PDN_OUT_LSB   = 8;
  localparam int PDN_ANA_LSB   = 4;
  localparam int INV_LSB       = 0;
  localparam logic [3:0] HPF_K_MIN = 4'h2;
  localparam logic [3:0] HPF_K_MAX = 4'ha;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* acg_axil_slave.sv */
// AXI4-Lite slave front end: takes one write and one read, returns one-cycle strobes
module acg_axil_slave (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite
  input  wire logic [11:0] s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [11:0] s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // Register side
  output logic             wr_go,
  output logic [11:0]      wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_ok,
  output logic             rd_go,
  output logic [11:0]      rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_ok
);
  logic aw_held_q, w_held_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      wr_addr   <= 12'h000;
      wr_data   <= 32'h0000_0000;
      wr_strb   <= 4'h0;
      wr_go     <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= acg_pkg::RESP_OKAY;
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
    end else begin
      wr_go <= 1'b0;
      // Registered ready: low while that channel is held or a response is still owed
      s_awready <= !(aw_held_q || (s_awvalid && s_awready)) && !wr_go &&
                   !(s_bvalid && !s_bready);
      s_wready  <= !(w_held_q || (s_wvalid && s_wready)) && !wr_go &&
                   !(s_bvalid && !s_bready);
      if (s_awvalid && s_awready) begin
        aw_held_q <= 1'b1;
        wr_addr   <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_held_q <= 1'b1;
        wr_data  <= s_wdata;
        wr_strb  <= s_wstrb;
      end
      if (aw_held_q && w_held_q && !wr_go && !s_bvalid) begin
        wr_go     <= 1'b1;
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
      end
      if (wr_go) begin
        s_bvalid <= 1'b1;
        s_bresp  <= wr_ok ? acg_pkg::RESP_OKAY : acg_pkg::RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      rd_go     <= 1'b0;
      rd_addr   <= 12'h000;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= acg_pkg::RESP_OKAY;
    end else begin
      rd_go     <= 1'b0;
      // Must not wait for arvalid to drop, or a held request would never be taken
      s_arready <= !rd_go && !s_rvalid;
      if (s_arvalid && s_arready) begin
        rd_go     <= 1'b1;
        rd_addr   <= s_araddr;
        s_arready <= 1'b0;
      end
      if (rd_go) begin
        s_rvalid <= 1'b1;
        s_rdata  <= rd_data;
        s_rresp  <= rd_ok ? acg_pkg::RESP_OKAY : acg_pkg::RESP_SLVERR;
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end
endmodule // acg_axil_slave

/* acg_regs.sv */
// Three 16-bit configuration registers with byte-lane write and decoded read
module acg_regs (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Access strobes
  input  wire logic        wr_go,
  input  wire logic [11:0] wr_addr,
  input  wire logic [31:0] wr_data,
  input  wire logic [3:0]  wr_strb,
  output logic             wr_ok,
  input  wire logic [11:0] rd_addr,
  output logic [31:0]      rd_data,
  output logic             rd_ok,
  // Register contents
  output logic [15:0]      pat_hpf_q,
  output logic [15:0]      insel_pat_q,
  output logic [15:0]      pdn_inv_q
);
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s, input logic [15:0] m);
    logic [15:0] n;
    n = old;
    if (s[0]) n[7:0] = d[7:0];
    if (s[1]) n[15:8] = d[15:8];
    return n & m;
  endfunction

  function automatic logic [1:0] decode(input logic [11:0] a);
    logic [1:0] r;
    r = 2'h3;
    if (a[11:2] == acg_pkg::ADDR_PAT_HPF[11:2]) r = 2'h0;
    else if (a[11:2] == acg_pkg::ADDR_INSEL_PAT[11:2]) r = 2'h1;
    else if (a[11:2] == acg_pkg::ADDR_PDN_INV[11:2]) r = 2'h2;
    return r;
  endfunction

  logic [1:0] wsel, rsel;
  assign wsel  = decode(wr_addr);
  assign rsel  = decode(rd_addr);
  assign wr_ok = (wsel != 2'h3);
  assign rd_ok = (rsel != 2'h3);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pat_hpf_q   <= acg_pkg::RST_PAT_HPF;   // [R7]
      insel_pat_q <= acg_pkg::RST_INSEL_PAT; // [R7]
      pdn_inv_q   <= acg_pkg::RST_PDN_INV;   // [R7]
    end else if (wr_go) begin
      // Reserved bits are never stored, so they cannot steer anything
      if (wsel == 2'h0)
        pat_hpf_q <= merge(pat_hpf_q, wr_data, wr_strb, acg_pkg::MASK_PAT_HPF); // [R7] [R8]
      if (wsel == 2'h1)
        insel_pat_q <= merge(insel_pat_q, wr_data, wr_strb, acg_pkg::MASK_INSEL_PAT); // [R8]
      if (wsel == 2'h2)
        pdn_inv_q <= merge(pdn_inv_q, wr_data, wr_strb, acg_pkg::MASK_PDN_INV); // [R7]
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    if (rsel == 2'h0) rd_data[15:0] = pat_hpf_q;
    else if (rsel == 2'h1) rd_data[15:0] = insel_pat_q;
    else if (rsel == 2'h2) rd_data[15:0] = pdn_inv_q;
  end

  a_reset_zero_a: assert property (@(posedge aclk) !aresetn |=> // [R7]
    (pat_hpf_q == 16'h0000 && insel_pat_q == 16'h0000 && pdn_inv_q == 16'h0000))
    else $error("register not zero after reset");
  a_reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
    pat_hpf_q[5] == 1'b0 && insel_pat_q[15:12] == 4'h0 && insel_pat_q[1:0] == 2'h0)
    else $error("reserved bit stored");
  a_write_store_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    wr_go && wsel == 2'h2 && wr_strb == 4'hf |=> pdn_inv_q == $past(wr_data[15:0]))
    else $error("write not stored");
endmodule // acg_regs

/* acg_tb.sv */
// Self-checking bench for the group-4 converter configuration bank
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn;
  logic [11:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  logic        independent_pattern_select, sixteen_input_mode;
  logic [3:0]  prbs_active, highpass_k_group4, digital_powerdown;
  logic [3:0]  output_powerdown, analog_powerdown, data_invert_active;
  logic [11:0] test_pattern_sel;
  logic        highpass_enable_group4, highpass_k_illegal;
  logic [31:0] input_pair_num;
  int          err_total, checks;
  logic [15:0] sh [3];
  logic [11:0] reg_addr [3];
  logic [15:0] reg_mask [3];
  logic [3:0]  ktab [6];

  acg_top dut (
    .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .independent_pattern_select,
    .sixteen_input_mode, .prbs_active, .test_pattern_sel, .highpass_enable_group4,
    .highpass_k_group4, .highpass_k_illegal, .input_pair_num, .digital_powerdown,
    .output_powerdown, .analog_powerdown, .data_invert_active
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Address and data offered together, each released once taken
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st,
                     output logic [1:0] rsp);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= d;
    s_wstrb <= st;
    s_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_awvalid && s_awready) begin
        aw_ok = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_ok = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    s_bready <= 1'b1;
    do @(posedge aclk); while (!s_bvalid);
    rsp = s_bresp;
    s_bready <= 1'b0;
  endtask

  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rsp);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_arready);
    s_arvalid <= 1'b0;
    s_rready <= 1'b1;
    do @(posedge aclk); while (!s_rvalid);
    d = s_rdata;
    rsp = s_rresp;
    s_rready <= 1'b0;
  endtask

  task automatic put(input int i, input logic [15:0] v);
    logic [1:0] rsp;
    axw(reg_addr[i], {16'h0000, v}, 4'hf, rsp);
    sh[i] = v & reg_mask[i];
    chk("bresp", {30'h0, acg_pkg::RESP_OKAY}, {30'h0, rsp});
  endtask

  task automatic get(input int i);
    logic [31:0] d;
    logic [1:0]  rsp;
    axr(reg_addr[i], d, rsp);
    chk("rdata", {16'h0000, sh[i]}, d);
    chk("rresp", {30'h0, acg_pkg::RESP_OKAY}, {30'h0, rsp});
  endtask

  // Every control output predicted from the shadow registers and mode inputs
  task automatic chk_out();
    logic [15:0] p, s, d;
    logic [3:0]  pr, inv;
    logic [11:0] tp;
    logic [31:0] ip;
    logic        en, bad;
    repeat (3) @(posedge aclk);
    p = sh[0];
    s = sh[1];
    d = sh[2];
    tp = independent_pattern_select ? {s[4:2], s[7:5], p[8:6], p[11:9]} : 12'h000;
    for (int i = 0; i < 4; i++) begin
      pr[i] = independent_pattern_select & p[15-i];
      inv[i] = d[i] & ~(pr[i] | (tp[i*3 +: 3] != 3'h0));
      ip[i*8 +: 8] = !sixteen_input_mode ? 8'h00 : s[11-i] ? 8'(26 + 2*i) : 8'(25 + 2*i);
    end
    en = p[0];
    bad = en && (p[4:1] < 4'h2 || p[4:1] > 4'ha);
    chk("prbs_active", {28'h0, pr}, {28'h0, prbs_active});
    chk("test_pattern_sel", {20'h0, tp}, {20'h0, test_pattern_sel});
    chk("hpf_enable", {31'h0, en}, {31'h0, highpass_enable_group4});
    chk("hpf_k", {28'h0, en ? p[4:1] : 4'h0}, {28'h0, highpass_k_group4});
    chk("hpf_k_illegal", {31'h0, bad}, {31'h0, highpass_k_illegal});
    chk("input_pair_num", ip, input_pair_num);
    chk("powerdown", {20'h0, d[15:4]},
        {20'h0, digital_powerdown, output_powerdown, analog_powerdown});
    chk("invert", {28'h0, inv}, {28'h0, data_invert_active});
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 3; i++) sh[i] = 16'h0000;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    close_out();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  rsp;
    aresetn = 1'b0;
    {s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready} = '0;
    {s_araddr, s_arvalid, s_rready} = '0;
    {independent_pattern_select, sixteen_input_mode} = 2'b00;
    reg_addr = '{acg_pkg::ADDR_PAT_HPF, acg_pkg::ADDR_INSEL_PAT, acg_pkg::ADDR_PDN_INV};
    reg_mask = '{acg_pkg::MASK_PAT_HPF, acg_pkg::MASK_INSEL_PAT, acg_pkg::MASK_PDN_INV};
    ktab = '{4'h0, 4'h1, 4'h2, 4'ha, 4'hb, 4'hf};
    @(posedge aclk);
    do_reset();
    for (int i = 0; i < 3; i++) get(i);
    chk_out();
    // Reserved positions must come back as zero
    for (int i = 0; i < 3; i++) begin
      put(i, 16'hffff);
      get(i);
    end
    axw(reg_addr[2], 32'h0000_0000, 4'h1, rsp);
    sh[2] = 16'hff00;
    get(2);
    // Unmapped word between two registers
    axw(12'h0e8, 32'hffff_ffff, 4'hf, rsp);
    chk("bresp_unmapped", {30'h0, acg_pkg::RESP_SLVERR}, {30'h0, rsp});
    axr(12'h0e8, d, rsp);
    chk("rdata_unmapped", 32'h0, d);
    chk("rresp_unmapped", {30'h0, acg_pkg::RESP_SLVERR}, {30'h0, rsp});
    for (int i = 0; i < 3; i++) get(i);
    put(0, 16'haac0);
    put(1, 16'h0ac8);
    put(2, 16'h1248);
    chk_out();
    independent_pattern_select <= 1'b1;
    sixteen_input_mode <= 1'b1;
    chk_out();
    put(2, 16'h000f);
    chk_out();
    put(1, 16'h0000);
    put(0, 16'h8000);
    chk_out();
    independent_pattern_select <= 1'b0;
    chk_out();
    for (int j = 0; j < 6; j++) begin
      for (int e = 0; e < 2; e++) begin
        put(0, {11'h000, ktab[j], e[0]});
        chk_out();
      end
    end
    // Second reset in mid-run clears everything again
    do_reset();
    for (int i = 0; i < 3; i++) get(i);
    chk_out();
    close_out();
  end
endmodule // tb
